// ===== verilog/afc_host.sv
// host controller that drives a 512x9 strobe fifo chip from axi4-lite registers
// Overview of operation
// - pulse init once before any write
// - chain-in level held during init selects mode
// - replay rewinds read pointer, stand-alone only
// - wait recovery after replay before reading
// - held write completes on next read
// - held read completes on next write
// - wide words share strobes, one flag source
// - first-unit select low marks first device
//
// Implementation choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module afc_host
	import afc_pkg::*;
#(
	parameter int DW = AFC_DW
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic [11:0]      s_axi_awaddr,
	input  wire logic             s_axi_awvalid,
	output logic                  s_axi_awready,
	input  wire logic [31:0]      s_axi_wdata,
	input  wire logic [3:0]       s_axi_wstrb,
	input  wire logic             s_axi_wvalid,
	output logic                  s_axi_wready,
	output logic [1:0]            s_axi_bresp,
	output logic                  s_axi_bvalid,
	input  wire logic             s_axi_bready,
	input  wire logic [11:0]      s_axi_araddr,
	input  wire logic             s_axi_arvalid,
	output logic                  s_axi_arready,
	output logic [31:0]           s_axi_rdata,
	output logic [1:0]            s_axi_rresp,
	output logic                  s_axi_rvalid,
	input  wire logic             s_axi_rready,
	output afc_strobes_t          pins,
	output logic [DW-1:0]         data_in_bus,
	input  wire logic [DW-1:0]    data_out_bus,
	input  wire afc_flags_t       flags
);
	afc_flags_t            flag_s1;
	afc_flags_t            flag_s2;
	logic [DW-1:0]         dout_s1;
	logic [DW-1:0]         dout_s2;
	afc_state_t            state;
	afc_state_t            next_state;
	logic [AFC_CNT_W-1:0]  cnt;
	logic [AFC_CNT_W-1:0]  next_cnt;
	logic                  inited;
	logic                  chained;
	logic                  chain_mode;
	logic                  first_unit;
	logic [DW-1:0]         wdata;
	logic [DW-1:0]         rdata;
	logic                  rvalid_flag;
	logic                  wpend;
	logic                  rpend;
	logic                  init_req;
	logic                  replay_req;
	logic                  aw_held;
	logic                  w_held;
	logic [11:0]           aw_addr;
	logic [31:0]           w_data;
	logic [3:0]            w_strb;

	// flags and read data come from another domain
	always_ff @(posedge aclk) begin
		flag_s1 <= flags;
		flag_s2 <= flag_s1;
		dout_s1 <= data_out_bus;
		dout_s2 <= dout_s1;
	end

	// write channel: address and data taken in either order
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take  = s_axi_wvalid && s_axi_wready;
	wire wr_fire = aw_held && w_held && !s_axi_bvalid;
	wire wr_ctrl = wr_fire && aw_addr == AFC_REG_CTRL && w_strb[0];
	wire wr_wdat = wr_fire && aw_addr == AFC_REG_WDATA && w_strb[0] && w_strb[1];
	wire wr_map  = aw_addr == AFC_REG_CTRL || aw_addr == AFC_REG_WDATA;
	wire rd_take = s_axi_arvalid && s_axi_arready;
	wire rd_rdat = rd_take && s_axi_araddr == AFC_REG_RDATA;
	wire busy    = state != AFC_IDLE || wpend || rpend || init_req || replay_req;
	// strobe phases ending this cycle
	wire wr_done   = state == AFC_WRITE && next_state == AFC_GAP;
	wire rd_done   = state == AFC_READ && next_state == AFC_GAP;
	wire init_done = state == AFC_INIT && next_state == AFC_GAP;

	// unmapped offsets read as zero

	function automatic logic [31:0] rd_mux(input logic [11:0] a);
		case (a)
			AFC_REG_CTRL:   rd_mux = {28'h0, first_unit, chained, 2'h0};
			AFC_REG_WDATA:  rd_mux = {{(32-DW){1'b0}}, wdata};
			AFC_REG_RDATA:  rd_mux = {{(32-DW){1'b0}}, rdata};
			AFC_REG_STATUS: rd_mux = {26'h0, rvalid_flag, inited, busy,
				flag_s2.half_flag_n, flag_s2.full_flag_n, flag_s2.empty_flag_n};
			default:        rd_mux = 32'h0;
		endcase
	endfunction

	function automatic logic rd_ok(input logic [11:0] a);
		rd_ok = a == AFC_REG_CTRL || a == AFC_REG_WDATA || a == AFC_REG_RDATA ||
			a == AFC_REG_STATUS;
	endfunction

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= AFC_RESP_OKAY;
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= 12'h000;
			w_data        <= 32'h0;
			w_strb        <= 4'h0;
		end else begin
			if (aw_take) begin
				aw_held       <= 1'b1;
				aw_addr       <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (w_take) begin
				w_held       <= 1'b1;
				w_data       <= s_axi_wdata;
				w_strb       <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_map ? AFC_RESP_OKAY : AFC_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= AFC_RESP_OKAY;
		end else if (rd_take) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_mux(s_axi_araddr);
			s_axi_rresp   <= rd_ok(s_axi_araddr) ? AFC_RESP_OKAY : AFC_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// requests latched from software; mode bits steer strap levels
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			chained     <= 1'b0;
			first_unit  <= 1'b1;
			wdata       <= '0;
			wpend       <= 1'b0;
			rpend       <= 1'b0;
			init_req    <= 1'b0;
			replay_req  <= 1'b0;
			rvalid_flag <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				chained    <= w_data[AFC_CTRL_CHAIN];
				first_unit <= w_data[AFC_CTRL_FIRST];
			end
			if (wr_ctrl && w_data[AFC_CTRL_INIT])
				init_req <= 1'b1;
			else if (state == AFC_INIT)
				init_req <= 1'b0;
			if (wr_ctrl && w_data[AFC_CTRL_REPLAY] && !chain_mode)
				replay_req <= 1'b1;
			else if (state == AFC_REPLAY)
				replay_req <= 1'b0;
			if (wr_wdat && inited) begin
				wdata <= w_data[DW-1:0];
				wpend <= 1'b1;
			end else if (wr_done)
				wpend <= 1'b0;
			if (wr_ctrl && w_data[AFC_CTRL_READ])
				rpend <= 1'b1;
			else if (rd_done)
				rpend <= 1'b0;
			// new capture wins over the read-out clear
			if (rd_done)
				rvalid_flag <= 1'b1;
			else if (rd_rdat)
				rvalid_flag <= 1'b0;
		end
	end

	// strobe sequencer; a strobe, once low, is held until the flag allows it
	always_comb begin
		next_state = state;
		next_cnt   = cnt;
		unique case (state)
			AFC_IDLE: begin
				next_cnt = AFC_CNT_W'(AFC_STROBE_CYC);
				if (init_req)
					next_state = AFC_INIT;
				else if (replay_req)
					next_state = AFC_REPLAY;
				else if (rpend)
					next_state = AFC_READ;
				else if (wpend)
					next_state = AFC_WRITE;
				if (init_req)
					next_cnt = AFC_CNT_W'(AFC_INIT_CYC);
			end
			AFC_WRITE, AFC_READ: begin
				// a held strobe counts only once its flag is high
				if ((state == AFC_WRITE ? flag_s2.full_flag_n : flag_s2.empty_flag_n)
					&& cnt != '0)
					next_cnt = cnt - 1'b1;
				if (cnt == '0) begin
					next_state = AFC_GAP;
					next_cnt   = AFC_CNT_W'(AFC_RECOVER_CYC);
				end
			end
			AFC_INIT: begin
				next_cnt = cnt - 1'b1;
				if (cnt == '0) begin
					next_state = AFC_GAP;
					next_cnt   = AFC_CNT_W'(AFC_RECOVER_CYC);
				end
			end
			AFC_REPLAY: begin
				next_cnt = cnt - 1'b1;
				if (cnt == '0) begin
					next_state = AFC_GAP;
					next_cnt   = AFC_CNT_W'(AFC_REPLAY_CYC);
				end
			end
			AFC_GAP: begin
				next_cnt = cnt - 1'b1;
				if (cnt == '0)
					next_state = AFC_IDLE;
			end
			// unused codes fall back to idle
			default: begin
				next_state = AFC_IDLE;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state  <= AFC_IDLE;
			cnt    <= '0;
			inited <= 1'b0;
			rdata  <= '0;
			chain_mode <= 1'b0;
		end else begin
			state <= next_state;
			cnt   <= next_cnt;
			// chip mode is fixed by the init pulse; later ctrl writes cannot move it
			if (init_done) begin
				inited     <= 1'b1;
				chain_mode <= chained;
			end
			if (rd_done)
				rdata <= dout_s2;
		end
	end

	// pins driven from flops
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pins        <= '{write_n: 1'b1, read_n: 1'b1, init_line_n: 1'b1,
				replay_n: 1'b1, chain_in_n: 1'b0, first_unit_sel_n: 1'b1};
			data_in_bus <= '0;
		end else begin
			pins.write_n          <= !(next_state == AFC_WRITE);
			pins.read_n           <= !(next_state == AFC_READ);
			pins.init_line_n      <= !(next_state == AFC_INIT);
			pins.replay_n         <= !(next_state == AFC_REPLAY && !chain_mode);
			pins.chain_in_n       <= chained;
			pins.first_unit_sel_n <= chained ? !first_unit : 1'b1;
			// write data frozen while the strobe is low
			if (pins.write_n)
				data_in_bus <= wdata;
		end
	end
endmodule

// ===== verilog/afc_pkg.sv
// package: constants, timing and carrier types for the fifo-chip host controller
package afc_pkg;
	localparam int AFC_DW        = 9;
	localparam int AFC_DEPTH     = 512;
	localparam int AFC_CLK_NS    = 25;
	// strobe and recovery times in ns
	localparam int AFC_STROBE_NS  = 35;
	localparam int AFC_RECOVER_NS = 10;
	localparam int AFC_REPLAY_NS  = 35;
	localparam int AFC_INIT_NS    = 100;
	localparam int AFC_STROBE_CYC  = (AFC_STROBE_NS + AFC_CLK_NS - 1) / AFC_CLK_NS;
	localparam int AFC_RECOVER_CYC = (AFC_RECOVER_NS + AFC_CLK_NS - 1) / AFC_CLK_NS;
	localparam int AFC_REPLAY_CYC  = (AFC_REPLAY_NS + AFC_CLK_NS - 1) / AFC_CLK_NS;
	localparam int AFC_INIT_CYC    = (AFC_INIT_NS + AFC_CLK_NS - 1) / AFC_CLK_NS;
	localparam int AFC_CNT_W       = 8;
	// register byte offsets
	localparam logic [11:0] AFC_REG_CTRL   = 12'h000;
	localparam logic [11:0] AFC_REG_WDATA  = 12'h004;
	localparam logic [11:0] AFC_REG_RDATA  = 12'h008;
	localparam logic [11:0] AFC_REG_STATUS = 12'h00C;
	// ctrl bits (write 1 to start init, replay, read; chain and first are held levels)
	localparam int AFC_CTRL_INIT   = 0;
	localparam int AFC_CTRL_REPLAY = 1;
	localparam int AFC_CTRL_CHAIN  = 2;
	localparam int AFC_CTRL_FIRST  = 3;
	localparam int AFC_CTRL_READ   = 4;
	// status bits
	localparam int AFC_ST_EMPTY_N = 0;
	localparam int AFC_ST_FULL_N  = 1;
	localparam int AFC_ST_HALF_N  = 2;
	localparam int AFC_ST_BUSY    = 3;
	localparam int AFC_ST_INITED  = 4;
	localparam int AFC_ST_RVALID  = 5;
	localparam logic [1:0] AFC_RESP_OKAY   = 2'h0;
	localparam logic [1:0] AFC_RESP_SLVERR = 2'h2;
	typedef struct packed {
		logic write_n;
		logic read_n;
		logic init_line_n;
		logic replay_n;
		logic chain_in_n;
		logic first_unit_sel_n;
	} afc_strobes_t;
	typedef struct packed {
		logic empty_flag_n;
		logic full_flag_n;
		logic half_flag_n;
	} afc_flags_t;
	typedef enum logic [2:0] {AFC_IDLE, AFC_INIT, AFC_WRITE, AFC_READ, AFC_REPLAY,
		AFC_GAP} afc_state_t;
endpackage

// ===== bench/afc_host_asserts.sv
// checker: strobe and pin timing of the fifo-chip host
`timescale 1ns/1ps
module afc_host_asserts
	import afc_pkg::*;
#(
	parameter int DW = AFC_DW
) (
	input wire logic          aclk,
	input wire logic          aresetn,
	input wire afc_strobes_t  pins,
	input wire logic [DW-1:0] data_in_bus,
	input wire afc_flags_t    flags
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic seen;
	always_ff @(posedge aclk) begin
		if (!aresetn) seen <= 1'b0;
		else if (!pins.init_line_n) seen <= 1'b1;
	end
	sequence init_low; !pins.init_line_n [*4]; endsequence
	sequence read_off2; pins.read_n [*2]; endsequence
	a_reset_idle: assert property (disable iff (1'b0) !aresetn |=> pins.write_n && pins.read_n
		&& pins.init_line_n && pins.replay_n) else $error("strobe active after reset");
	a_write_inited: assert property (!pins.write_n |-> seen) else $error("write before init");
	a_write_room: assert property ($fell(pins.write_n) |-> $past(flags.full_flag_n))
		else $error("write started while full");
	a_read_avail: assert property ($fell(pins.read_n) |-> $past(flags.empty_flag_n))
		else $error("read started while empty");
	a_init_width: assert property ($fell(pins.init_line_n) |-> init_low)
		else $error("init pulse too short");
	a_chain_steady: assert property (!pins.init_line_n && !$past(pins.init_line_n)
		|-> $stable(pins.chain_in_n)) else $error("chain level moved during init");
	a_replay_solo: assert property (!pins.replay_n |-> !pins.chain_in_n)
		else $error("replay while chained");
	a_replay_gap: assert property ($rose(pins.replay_n) |-> read_off2)
		else $error("read too soon after replay");
	a_wdata_steady: assert property (!pins.write_n && !$past(pins.write_n)
		|-> $stable(data_in_bus)) else $error("write data moved under strobe");
endmodule
bind afc_host afc_host_asserts #(.DW(DW)) i_afc_host_asserts (.aclk(aclk), .aresetn(aresetn),
	.pins(pins), .data_in_bus(data_in_bus), .flags(flags));

// ===== bench/afc_chip_model.sv
// behavioural 512x9 strobe fifo chip on the far side of the host
`timescale 1ns/1ps
module afc_chip_model
	import afc_pkg::*;
(
	input wire afc_strobes_t pins,
	input wire logic [8:0]   din,
	output logic [8:0]       dout,
	output afc_flags_t       flags
);
	logic [8:0] mem [AFC_DEPTH];
	logic [8:0] q = 9'h000;
	int         wp, rp, cnt;
	bit         wpend, rpend, chained, en, hit;
	assign flags.full_flag_n = cnt + wpend < AFC_DEPTH;
	assign flags.empty_flag_n = cnt - rpend > 0;
	assign flags.half_flag_n = chained || cnt <= AFC_DEPTH / 2;
	// released bus shows the inverse of the last word
	assign dout = rpend ? q : ~q;
	task automatic start_rd;
		q = mem[rp];
		rpend = 1;
	endtask
	always @(negedge pins.init_line_n) begin
		{wp, rp, cnt} = '0;
		{wpend, rpend, hit} = 3'h1;
	end
	always @(posedge pins.init_line_n) begin
		chained = pins.chain_in_n;
		en = hit && (!chained || !pins.first_unit_sel_n);
	end
	always @(negedge pins.write_n) if (en && flags.full_flag_n) wpend = 1;
	always @(posedge pins.write_n) if (wpend) begin
		mem[wp] = din;
		wp = (wp + 1) % AFC_DEPTH;
		wpend = 0;
		cnt++;
		if (!pins.read_n && !rpend) start_rd();
	end
	always @(negedge pins.read_n) if (en && flags.empty_flag_n) start_rd();
	always @(posedge pins.read_n) if (rpend) begin
		rp = (rp + 1) % AFC_DEPTH;
		rpend = 0;
		cnt--;
		if (!pins.write_n && !wpend) wpend = 1;
	end
	always @(negedge pins.replay_n) if (!chained) begin
		rp = 0;
		cnt = wp;
	end
endmodule

// ===== bench/tb_top.sv
// testbench: axi4-lite driven host against the chip model
`timescale 1ns/1ps
module tb_top
	import afc_pkg::*;
;
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, ch = 0;
	logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, r;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	afc_strobes_t pins;
	afc_flags_t flags;
	logic [8:0] data_in_bus, data_out_bus;
	logic [8:0] exp_q [$], h [$];
	int fail_count = 0, compares = 0, cyc = 0;
	afc_host i_afc_host (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pins, .data_in_bus, .data_out_bus, .flags);
	afc_chip_model i_chip (.pins, .din(data_in_bus), .dout(data_out_bus), .flags);
	initial forever #12.5 aclk = ~aclk;
	task automatic give_verdict;
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	always @(posedge aclk) begin
		cyc++;
		if (cyc > 60000) begin
			fail_count++;
			give_verdict;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		{r, rs} = {s_axi_rdata, s_axi_rresp};
		s_axi_rready <= 1'b0;
	endtask
	function automatic logic [2:0] expf(int n);
		return {ch || n <= AFC_DEPTH / 2, n < AFC_DEPTH, n > 0};
	endfunction
	task automatic idle;
		do rd(AFC_REG_STATUS); while (r[AFC_ST_BUSY] !== 1'b0);
	endtask
	task automatic stat;
		rd(AFC_REG_STATUS);
		chk(r[2:0], expf(exp_q.size()));
	endtask
	task automatic cmd(input logic [31:0] d);
		// keep the mode bits on every ctrl write
		wr(AFC_REG_CTRL, d | (32'(ch) << AFC_CTRL_CHAIN) | (32'(ch) << AFC_CTRL_FIRST));
		idle;
	endtask
	task automatic push(int n);
		logic [8:0] d;
		repeat (n) begin
			d = 9'($urandom);
			wr(AFC_REG_WDATA, {23'h0, d});
			idle;
			exp_q.push_back(d);
			stat;
		end
	endtask
	task automatic pop(int n);
		repeat (n) begin
			cmd(1 << AFC_CTRL_READ);
			rd(AFC_REG_RDATA);
			chk(r[8:0], exp_q.pop_front());
			stat;
		end
	endtask
	initial begin
		void'($urandom(14));
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		wr(AFC_REG_WDATA, 32'h0AB);
		idle;
		stat;
		chk(r[AFC_ST_INITED], 0);
		$display("test pre-init done");
		cmd(1 << AFC_CTRL_INIT);
		stat;
		push(AFC_DEPTH);
		pop(AFC_DEPTH);
		$display("test fill and drain done");
		cmd(1 << AFC_CTRL_INIT);
		push(5);
		h = exp_q;
		pop(3);
		cmd(1 << AFC_CTRL_REPLAY);
		exp_q = h;
		stat;
		pop(5);
		$display("test replay done");
		ch = 1;
		cmd(32'h0000000D);
		rd(AFC_REG_CTRL);
		chk(r[3:2], 2'h3);
		push(2);
		pop(1);
		cmd(1 << AFC_CTRL_REPLAY);
		pop(1);
		$display("test chained done");
		wr(12'h010, 32'h0);
		chk(rs, AFC_RESP_SLVERR);
		rd(12'h010);
		chk(r, 32'h0);
		chk(rs, AFC_RESP_SLVERR);
		$display("test unmapped done");
		give_verdict;
	end
endmodule
